// ===== sac_top.sv
// Converter control top: register slave, conversion control, flags and pin control.
// ------------------------------------------------------------
// Summary of operation
// RQ1: Ten-bit result by successive approximation, held.
// RQ2: Fourteen inputs muxed into one sample stage.
// RQ3: Channel field bits 5..2 choose the input.
// RQ4: Bit 6 picks external reference or supply.
// RQ5: One conversion lasts eleven bit periods.
// RQ6: Clock code sets period divider or RC.
// RQ7: Software keeps bit period at least 1.6 us.
// RQ8: Software uses RC clock above 1 MHz only asleep.
// RQ9: Writing go bit starts a conversion.
// RQ10: Completion clears go, sets flag, interrupts.
// RQ11: Clearing go aborts; old result kept.
// RQ12: After abort wait two periods, then acquire.
// RQ13: Software enables converter before setting go.
// RQ14: Justify bit selects left or right result.
// RQ15: Analog select bits disable digital input buffers.
// RQ16: Direction bit one releases the pin driver.
// RQ17: Analog pins read back as zero.
// ------------------------------------------------------------
`timescale 1ns/1ns
`include "sac_defines.svh"
module sac_top
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt
  output logic             irq,
  // Analog core
  input  wire logic        cmpHigh,
  input  wire logic        frcTick,
  output logic             converterOn,
  output logic [3:0]       channelSelect,
  output logic             referenceSourceSelect,
  output logic             acquire,
  output logic [9:0]       dacCode,
  // Pins
  input  wire logic [11:0] pinIn,
  output logic [11:0]      pinOut,
  output logic [11:0]      pinOeN,
  output logic [11:0]      digitalInDisable
);
  import sac_pkg::*;

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdMux;
  logic        wrAck;
  logic        rdAck;

  logic [7:0]  ctlFirst_q;
  logic [2:0]  clockSel_q;
  logic [7:0] anselLow_q;
  logic [3:0]  anselHigh_q;
  logic [7:0]  resUpper_q;
  logic [7:0]  resLower_q;
  logic [7:0]  flags_q;
  logic [7:0]  flagMask_q;
  logic [11:0] pinDir_q;
  logic [11:0] pinOut_q;
  logic        irq_q;
  logic        acquire_q;
  logic [11:0] anselAll;

  sac_state_t  coreState;
  logic        coreDone;
  logic [9:0]  coreTrial;
  logic [9:0]  coreResult;
  logic        tadTick;
  logic        start;
  logic        keepGoing;
  logic        busy;
  logic        abortNow;
  logic        tadRun;

  assign wrAck    = avs_write && !wait_q;
  assign rdAck    = avs_read && !wait_q;
  assign anselAll = {anselHigh_q, anselLow_q};

  assign avs_waitrequest       = wait_q;
  assign avs_readdata          = rdata_q;
  assign irq                   = irq_q;
  assign converterOn           = ctlFirst_q[`SAC_BIT_ON];
  assign channelSelect         = ctlFirst_q[`SAC_CHS_MSB:`SAC_CHS_LSB]; // RQ3
  assign referenceSourceSelect = ctlFirst_q[`SAC_BIT_REF]; // RQ4
  assign acquire               = acquire_q;
  assign dacCode               = coreTrial;
  assign pinOut                = pinOut_q;
  assign pinOeN                = pinDir_q; // RQ16
  assign digitalInDisable      = anselAll; // RQ15

  // Read data are captured in the wait cycle, so every access takes two edges.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      wait_q <= 1'b1;
    else
      wait_q <= !((avs_read || avs_write) && wait_q);
  end

  always_comb
  begin
    rdMux = 32'h0000_0000;
    case (avs_address)
      `SAC_IDX_CTL_FIRST:  rdMux[7:0]  = ctlFirst_q;
      `SAC_IDX_CTL_SECOND: rdMux[`SAC_CKS_MSB:`SAC_CKS_LSB] = clockSel_q;
      `SAC_IDX_ANSEL_LOW:  rdMux[7:0]  = anselLow_q;
      `SAC_IDX_ANSEL_HIGH: rdMux[3:0]  = anselHigh_q;
      `SAC_IDX_RES_UPPER:  rdMux[7:0]  = resUpper_q;
      `SAC_IDX_RES_LOWER:  rdMux[7:0]  = resLower_q;
      `SAC_IDX_FLAGS:      rdMux[7:0]  = flags_q;
      `SAC_IDX_FLAG_MASK:  rdMux[7:0]  = flagMask_q;
      `SAC_IDX_PIN_DIR:    rdMux[11:0] = pinDir_q;
      `SAC_IDX_PIN_OUT:    rdMux[11:0] = pinOut_q;
      `SAC_IDX_PIN_READ:   rdMux[11:0] = pinIn & ~anselAll; // RQ17
      default:             rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_q <= 32'h0000_0000;
    else if (avs_read && wait_q)
      rdata_q <= rdMux;
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  // A software write in the completion cycle wins, so a new go is never dropped.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      ctlFirst_q <= `SAC_RST_BYTE;
    else if (wrAck && avs_address == `SAC_IDX_CTL_FIRST)
      ctlFirst_q <= avs_writedata[7:0]; // RQ9
    else if (coreDone)
      ctlFirst_q[`SAC_BIT_GO] <= 1'b0; // RQ10
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      clockSel_q <= 3'b000;
    else if (wrAck && avs_address == `SAC_IDX_CTL_SECOND)
      clockSel_q <= avs_writedata[`SAC_CKS_MSB:`SAC_CKS_LSB];
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      anselLow_q  <= `SAC_RST_ANSEL_LOW;
      anselHigh_q <= `SAC_RST_ANSEL_HIGH;
      pinDir_q    <= `SAC_RST_PIN_DIR;
      pinOut_q    <= 12'h000;
      flagMask_q  <= `SAC_RST_BYTE;
    end
    else if (wrAck)
    begin
      case (avs_address)
        `SAC_IDX_ANSEL_LOW:  anselLow_q  <= avs_writedata[7:0]; // RQ15
        `SAC_IDX_ANSEL_HIGH: anselHigh_q <= avs_writedata[3:0]; // RQ15
        `SAC_IDX_PIN_DIR:    pinDir_q    <= avs_writedata[11:0]; // RQ16
        `SAC_IDX_PIN_OUT:    pinOut_q    <= avs_writedata[11:0];
        `SAC_IDX_FLAG_MASK:  flagMask_q  <= avs_writedata[7:0];
        default:             ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Conversion control
  // ------------------------------------------------------------
  assign busy      = (coreState != SAC_IDLE);
  assign keepGoing = ctlFirst_q[`SAC_BIT_GO] && ctlFirst_q[`SAC_BIT_ON]; // RQ11
  assign start     = keepGoing && !busy && !coreDone; // RQ9
  // Restarting the divider on an abort makes both wait periods whole bit periods.
  assign abortNow  = (coreState == SAC_CONV) && !keepGoing;
  assign tadRun    = busy && !abortNow; // RQ12

  sac_tad_gen u_tad
  (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clkSel  (clockSel_q),
    .run     (tadRun),
    .frcTick (frcTick),
    .tadTick (tadTick)
  );

  sac_sar_core u_core
  (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .start     (start),
    .keepGoing (keepGoing),
    .tadTick   (tadTick),
    .cmpHigh   (cmpHigh),
    .state     (coreState),
    .done      (coreDone),
    .trial     (coreTrial),
    .result    (coreResult)
  );

  // The sample stage tracks the selected channel while the converter is on and no conversion or wait runs.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      acquire_q <= 1'b0;
    else
      acquire_q <= ctlFirst_q[`SAC_BIT_ON] && !busy && !start; // RQ2 RQ12
  end

  // Only a completed conversion touches the result pair; an abort never does.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      resUpper_q <= `SAC_RST_BYTE;
      resLower_q <= `SAC_RST_BYTE;
    end
    else if (coreDone)
    begin
      if (ctlFirst_q[`SAC_BIT_JUSTIFY])
      begin
        resUpper_q <= {6'b00_0000, coreResult[9:8]}; // RQ14
        resLower_q <= coreResult[7:0];
      end
      else
      begin
        resUpper_q <= coreResult[9:2]; // RQ14
        resLower_q <= {coreResult[1:0], 6'b00_0000};
      end
    end
  end

  // ------------------------------------------------------------
  // Flags and interrupt
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      flags_q <= `SAC_RST_BYTE;
    else
    begin
      if (wrAck && avs_address == `SAC_IDX_FLAGS)
        flags_q <= flags_q & ~avs_writedata[7:0];
      if (coreDone)
        flags_q[`SAC_BIT_DONE_FLAG] <= 1'b1; // RQ10
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_q <= 1'b0;
    else
      irq_q <= |(flags_q & flagMask_q); // RQ10
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [9:0] busyCycles_q;
  logic [7:0] waitCycles_q;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      busyCycles_q <= 10'd0;
    else if (busy)
      busyCycles_q <= busyCycles_q + 10'd1;
    else
      busyCycles_q <= 10'd0;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      waitCycles_q <= 8'd0;
    else if (coreState == SAC_WAIT)
      waitCycles_q <= waitCycles_q + 8'd1;
    else
      waitCycles_q <= 8'd0;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence sCtlWrite;
    wrAck && avs_address == `SAC_IDX_CTL_FIRST;
  endsequence

  sequence sAbort;
    coreState == SAC_CONV && !keepGoing;
  endsequence

  sequence sWaitEnd;
    coreState == SAC_WAIT ##1 coreState == SAC_IDLE;
  endsequence

  go_clear_done_a: assert property (coreDone // RQ10
    && !(wrAck && avs_address == `SAC_IDX_CTL_FIRST) |=>
    !ctlFirst_q[`SAC_BIT_GO] ##1 irq_q || !flagMask_q[`SAC_BIT_DONE_FLAG])
    else $error("go bit or interrupt wrong after completion");
  flag_set_done_a: assert property (coreDone |=> flags_q[`SAC_BIT_DONE_FLAG]) // RQ10
    else $error("completion flag not set");
  result_keep_abort_a: assert property (!coreDone |=> $stable({resUpper_q, resLower_q})) // RQ11
    else $error("result changed without completion");
  conv_length_a: assert property (coreDone && !sac_is_rc(clockSel_q) |-> // RQ5
    busyCycles_q == 10'(11 * (32'd1 << sac_div_exp(clockSel_q)) + 1))
    else $error("conversion length wrong");
  abort_wait_a: assert property (sAbort ##1 (coreState == SAC_WAIT)[*2] |-> // RQ12
    !acquire_q ##0 !coreDone)
    else $error("acquisition during abort wait");
  wait_length_a: assert property (sWaitEnd ##0 !sac_is_rc(clockSel_q) |-> // RQ12
    waitCycles_q == 8'(`SAC_ABORT_TADS * (32'd1 << sac_div_exp(clockSel_q)) + 1))
    else $error("abort wait length wrong");
  start_go_a: assert property (sCtlWrite ##0 avs_writedata[1:0] == 2'b11 && !busy // RQ9
    |=> ##1 coreState == SAC_CONV)
    else $error("go did not start conversion");
  justify_a: assert property (coreDone |=> ctlFirst_q[`SAC_BIT_JUSTIFY] ? // RQ14
    resUpper_q[7:2] == 6'b00_0000 : resLower_q[5:0] == 6'b00_0000)
    else $error("result justification wrong");
  chan_ref_a: assert property (sCtlWrite |=> // RQ3
    channelSelect == $past(avs_writedata[5:2]) && referenceSourceSelect == $past(avs_writedata[6]))
    else $error("channel or reference not applied");
  pin_dir_a: assert property (wrAck && avs_address == `SAC_IDX_PIN_DIR |=> // RQ16
    pinOeN == $past(avs_writedata[11:0]))
    else $error("direction not applied to driver enable");
  analog_read_a: assert property (rdAck && avs_address == `SAC_IDX_PIN_READ |-> // RQ17
    (avs_readdata[11:0] & anselAll) == 12'h000)
    else $error("analog pin read back non zero");
endmodule

// ===== sac_defines.svh
// Register map, field positions, reset values and timing counts of the converter control.
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define SAC_IDX_CTL_FIRST    8'h1F
`define SAC_IDX_RES_UPPER    8'h1E
`define SAC_IDX_ANSEL_LOW    8'h91
`define SAC_IDX_ANSEL_HIGH   8'h93
`define SAC_IDX_RES_LOWER    8'h9E
`define SAC_IDX_CTL_SECOND   8'h9F
`define SAC_IDX_FLAGS        8'hA0
`define SAC_IDX_FLAG_MASK    8'hA1
`define SAC_IDX_PIN_DIR      8'hA2
`define SAC_IDX_PIN_OUT      8'hA3
`define SAC_IDX_PIN_READ     8'hA4

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SAC_BIT_ON           0
`define SAC_BIT_GO           1
`define SAC_CHS_LSB          2
`define SAC_CHS_MSB          5
`define SAC_BIT_REF          6
`define SAC_BIT_JUSTIFY      7
`define SAC_CKS_LSB          4
`define SAC_CKS_MSB          6
`define SAC_BIT_DONE_FLAG    6

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SAC_RST_ANSEL_LOW    8'hFF
`define SAC_RST_ANSEL_HIGH   4'hF
`define SAC_RST_PIN_DIR      12'hFFF
`define SAC_RST_BYTE         8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SAC_CONV_TADS        4'd11
`define SAC_ABORT_TADS       4'd2
`define SAC_RESULT_MSB_MASK  10'h200
`define SAC_CLK_PERIOD_NS    100
`define SAC_TAD_MIN_NS       1600
`define SAC_TAD_MIN_CYCLES   ((`SAC_TAD_MIN_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)

`endif

// ===== sac_pkg.sv
// Types and shared decode functions of the converter control.
package sac_pkg;

  typedef enum logic [1:0]
  {
    SAC_IDLE = 2'b00,
    SAC_CONV = 2'b01,
    SAC_WAIT = 2'b11
  } sac_state_t;

  // Divider exponent: codes 000,100,001,101,010,110 give 2,4,8,16,32,64.
  function automatic logic [2:0] sac_div_exp(input logic [2:0] sel);
    sac_div_exp = 3'd1 + {2'b00, sel[2]} + {sel[1:0], 1'b0};
  endfunction

  function automatic logic sac_is_rc(input logic [2:0] sel);
    sac_is_rc = (sel[1:0] == 2'b11);
  endfunction

endpackage

// ===== sac_tad_gen.sv
// Conversion bit period tick generator.
`timescale 1ns/1ns
module sac_tad_gen
  import sac_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic [2:0] clkSel,
  input  wire logic       run,
  input  wire logic       frcTick,
  // Tick
  output logic            tadTick
);
  logic [5:0] cnt_q;
  logic [6:0] limit;
  logic       term;
  logic       tick_q;

  assign limit = 7'(7'd1 << sac_div_exp(clkSel)) - 7'd1;
  assign term  = (cnt_q == limit[5:0]);
  assign tadTick = tick_q;

  // The divider restarts with every conversion so that each bit period is whole.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_q <= 6'h00;
    else if (!run || term)
      cnt_q <= 6'h00;
    else
      cnt_q <= cnt_q + 6'd1;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      tick_q <= 1'b0;
    else
      tick_q <= run && (sac_is_rc(clkSel) ? frcTick : term); // RQ6
  end
endmodule

// ===== sac_sar_core.sv
// Successive approximation sequencer with abort and post-abort wait.
`timescale 1ns/1ns
module sac_sar_core
  import sac_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       start,
  input  wire logic       keepGoing,
  input  wire logic       tadTick,
  input  wire logic       cmpHigh,
  // Status and data
  output sac_state_t      state,
  output logic            done,
  output logic [9:0]      trial,
  output logic [9:0]      result
);
  sac_state_t state_q;
  logic [3:0] tadCnt_q;
  logic [9:0] mask_q;
  logic [9:0] trial_q;
  logic [9:0] result_q;
  logic       done_q;
  logic [9:0] kept;

  assign state  = state_q;
  assign done   = done_q;
  assign trial  = trial_q;
  assign result = result_q;
  assign kept   = cmpHigh ? trial_q : (trial_q & ~mask_q);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q  <= SAC_IDLE;
      tadCnt_q <= 4'd0;
    end
    else
    begin
      case (state_q)
        SAC_IDLE:
          if (start)
          begin
            state_q  <= SAC_CONV;
            tadCnt_q <= 4'd0;
          end
        SAC_CONV:
          if (!keepGoing)
          begin
            state_q  <= SAC_WAIT; // RQ11
            tadCnt_q <= 4'd0;
          end
          else if (tadTick)
          begin
            tadCnt_q <= tadCnt_q + 4'd1;
            if (tadCnt_q == `SAC_CONV_TADS - 4'd1)
              state_q <= SAC_IDLE; // RQ5
          end
        SAC_WAIT:
          if (tadTick)
          begin
            tadCnt_q <= tadCnt_q + 4'd1;
            if (tadCnt_q == `SAC_ABORT_TADS - 4'd1)
              state_q <= SAC_IDLE; // RQ12
          end
        default:
          state_q <= SAC_IDLE;
      endcase
    end
  end

  // First period samples; the next ten resolve one bit each, most significant first.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mask_q  <= 10'h000;
      trial_q <= 10'h000;
    end
    else if (state_q == SAC_IDLE && start)
    begin
      mask_q  <= `SAC_RESULT_MSB_MASK;
      trial_q <= 10'h000;
    end
    else if (state_q == SAC_CONV && keepGoing && tadTick)
    begin
      if (tadCnt_q == 4'd0)
        trial_q <= `SAC_RESULT_MSB_MASK;
      else
      begin
        trial_q <= kept | (mask_q >> 1); // RQ1
        mask_q  <= mask_q >> 1;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      done_q   <= 1'b0;
      result_q <= 10'h000;
    end
    else
    begin
      done_q <= 1'b0;
      if (state_q == SAC_CONV && keepGoing && tadTick && tadCnt_q == `SAC_CONV_TADS - 4'd1)
      begin
        done_q   <= 1'b1;
        result_q <= kept; // RQ1
      end
    end
  end
endmodule

// ===== sac_analog_model.sv
// Behavioural analog sample-and-hold, comparator and internal RC clock facing the control.
`timescale 1ns/1ns
module sac_analog_model
#(
  parameter int RC_CYCLES = 40
)
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // Control from the block
  input  wire logic         acquire,
  input  wire logic [3:0]   channelSelect,
  input  wire logic [9:0]   dacCode,
  // Levels of the fourteen channels, ten bits each
  input  wire logic [139:0] levels,
  // Answers to the block
  output logic              cmpHigh,
  output logic              frcTick
);
  logic [9:0] heldQ;
  int         rcCount;

  // The hold stage tracks only while acquiring, so a late level change cannot leak in.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      heldQ <= 10'h000;
    else if (acquire && channelSelect < 4'hE)
      heldQ <= levels[channelSelect * 10 +: 10];
  end

  assign cmpHigh = (heldQ >= dacCode);

  // A 4 us RC period keeps the bit period above the 1.6 us minimum.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rcCount <= 0;
      frcTick <= 1'b0;
    end
    else
    begin
      rcCount <= (rcCount == RC_CYCLES - 1) ? 0 : rcCount + 1;
      frcTick <= (rcCount == RC_CYCLES - 1);
    end
  end
endmodule

// ===== sac_top_bench.sv
// Self-checking bench of the converter control with its analog partner.
`timescale 1ns/1ns
`include "sac_defines.svh"
module sac_top_bench;
  logic         mclk;
  logic         sys_rst;
  logic [7:0]   avs_address;
  logic         avs_read;
  logic         avs_write;
  logic [31:0]  avs_writedata;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  logic         irq;
  logic         cmpHigh;
  logic         frcTick;
  logic         converterOn;
  logic [3:0]   channelSelect;
  logic         referenceSourceSelect;
  logic         acquire;
  logic [9:0]   dacCode;
  logic [11:0]  pinIn;
  logic [11:0]  pinOut;
  logic [11:0]  pinOeN;
  logic [11:0]  digitalInDisable;
  logic [139:0] levels;
  logic [31:0]  rd;
  logic [31:0]  a;
  logic [31:0]  b;
  logic [15:0]  lastRes;
  logic [7:0]   rIdx [7];
  logic [31:0]  rExp [7];
  logic [2:0]   codes [7];
  int           errors;
  int           checks_done;
  int           cycles;
  int           n;

  sac_top i_sac_top (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .cmpHigh(cmpHigh), .frcTick(frcTick), .converterOn(converterOn),
    .channelSelect(channelSelect), .referenceSourceSelect(referenceSourceSelect),
    .acquire(acquire), .dacCode(dacCode), .pinIn(pinIn), .pinOut(pinOut),
    .pinOeN(pinOeN), .digitalInDisable(digitalInDisable));

  sac_analog_model i_sac_analog_model (.mclk(mclk), .sys_rst(sys_rst), .acquire(acquire),
    .channelSelect(channelSelect), .dacCode(dacCode), .levels(levels),
    .cmpHigh(cmpHigh), .frcTick(frcTick));

  // ------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_range(input int got, input int lo, input int hi, input string what);
    checks_done++;
    if (got < lo || got > hi)
    begin
      errors++;
      $display("wrong value at %0t: %s took %0d, not in %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  // Holds the request until waitrequest is seen low, then takes read data at that edge.
  task automatic bus_access(input logic wr, input logic [7:0] idx, input logic [31:0] data);
    @(posedge mclk);
    avs_address   <= idx;
    avs_writedata <= data;
    avs_write     <= wr;
    avs_read      <= !wr;
    do
      @(posedge mclk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    // One more edge lets the access settle before the caller looks at outputs.
    @(posedge mclk);
  endtask

  function automatic logic [15:0] fmt(input logic [9:0] v, input logic right);
    fmt = right ? {6'h00, v} : {v, 6'h00};
  endfunction

  task automatic convert(input logic [2:0] code, input logic [3:0] ch, input logic useIrq,
                         input int lo, input int hi);
    logic [9:0] lvl;
    logic [7:0] ctl;
    int         t0;
    int         k;
    lvl = 10'($urandom);
    ctl = {1'($urandom), 1'($urandom), ch, 2'b01};
    levels[ch * 10 +: 10] <= lvl;
    bus_access(1'b1, `SAC_IDX_FLAG_MASK, {25'h0, useIrq, 6'h00});
    bus_access(1'b1, `SAC_IDX_CTL_SECOND, {25'h0, code, 4'h0});
    bus_access(1'b1, `SAC_IDX_CTL_FIRST, {24'h0, ctl});
    check_val({30'h0, referenceSourceSelect, converterOn}, {30'h0, ctl[6], 1'b1}, "ref");
    check_val({28'h0, channelSelect}, {28'h0, ch}, "channel");
    bus_access(1'b1, `SAC_IDX_CTL_FIRST, {24'h0, ctl | 8'h02});
    t0 = cycles;
    k = 0;
    do
    begin
      bus_access(1'b0, `SAC_IDX_CTL_FIRST, 32'h0);
      k++;
    end
    while (rd[1] !== 1'b0 && k < 400);
    check_range(cycles - t0, lo, hi, "conversion");
    repeat (2) @(posedge mclk);
    check_val({31'h0, irq}, {31'h0, useIrq}, "irq after done");
    bus_access(1'b0, `SAC_IDX_FLAGS, 32'h0);
    check_val(rd, 32'h40, "complete flag");
    lastRes = fmt(lvl, ctl[7]);
    bus_access(1'b0, `SAC_IDX_RES_UPPER, 32'h0);
    check_val(rd, {24'h0, lastRes[15:8]}, "result upper");
    bus_access(1'b0, `SAC_IDX_RES_LOWER, 32'h0);
    check_val(rd, {24'h0, lastRes[7:0]}, "result lower");
    bus_access(1'b1, `SAC_IDX_FLAGS, 32'h40);
    repeat (2) @(posedge mclk);
    check_val({31'h0, irq}, 32'h0, "irq after clear");
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    errors = 0;
    checks_done = 0;
    cycles = 0;
    sys_rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    pinIn = 12'h000;
    levels = '0;
    rIdx = '{`SAC_IDX_ANSEL_LOW, `SAC_IDX_ANSEL_HIGH, `SAC_IDX_PIN_DIR, `SAC_IDX_CTL_FIRST,
             `SAC_IDX_CTL_SECOND, `SAC_IDX_FLAGS, 8'h50};
    rExp = '{32'h0000_00FF, 32'h0000_000F, 32'h0000_0FFF, 32'h0, 32'h0, 32'h0, 32'h0};
    codes = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110, 3'b011};
    rd = $urandom(32'h4264d00a);
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    check_val({20'h0, pinOeN}, 32'h0000_0FFF, "pin enables");
    for (int i = 0; i < 7; i++)
    begin
      bus_access(1'b0, rIdx[i], 32'h0);
      check_val(rd, rExp[i], "reset value");
    end
    bus_access(1'b1, 8'h50, 32'hFFFF_FFFF);
    bus_access(1'b0, 8'h50, 32'h0);
    check_val(rd, 32'h0, "unmapped");
    $display("test reset values done");
    for (int i = 0; i < 4; i++)
    begin
      a = (i == 0) ? 32'h0000_FFFF : $urandom;
      b = $urandom;
      pinIn <= b[27:16];
      bus_access(1'b1, `SAC_IDX_ANSEL_LOW, {24'h0, a[7:0]});
      bus_access(1'b1, `SAC_IDX_ANSEL_HIGH, {24'h0, a[15:8]});
      bus_access(1'b1, `SAC_IDX_PIN_DIR, {20'h0, b[11:0]});
      bus_access(1'b1, `SAC_IDX_PIN_OUT, {20'h0, a[27:16]});
      check_val({20'h0, digitalInDisable}, {20'h0, a[11:0]}, "input disable");
      check_val({20'h0, pinOeN}, {20'h0, b[11:0]}, "pin enables");
      check_val({20'h0, pinOut}, {20'h0, a[27:16]}, "pin out");
      bus_access(1'b0, `SAC_IDX_ANSEL_HIGH, 32'h0);
      check_val(rd, {28'h0, a[11:8]}, "select high");
      bus_access(1'b0, `SAC_IDX_PIN_READ, 32'h0);
      check_val(rd, {20'h0, b[27:16] & ~a[11:0]}, "pin read");
    end
    $display("test pins done");
    for (int i = 0; i < 7; i++)
    begin
      n = 22 << i;
      if (i < 6)
        convert(codes[i], (i == 0) ? 4'd0 : (i == 1) ? 4'd13 : 4'($urandom_range(13)),
                i[0], n, n + 8);
      else
        convert(codes[i], 4'($urandom_range(13)), 1'b1, 400, 540);
    end
    $display("test conversions done");
    levels[9:0] <= ~lastRes[9:0];
    bus_access(1'b1, `SAC_IDX_CTL_SECOND, 32'h0000_0010);
    bus_access(1'b1, `SAC_IDX_CTL_FIRST, 32'h0000_0081);
    bus_access(1'b1, `SAC_IDX_CTL_FIRST, 32'h0000_0083);
    repeat (20) @(posedge mclk);
    check_val({31'h0, acquire}, 32'h0, "acquire in conversion");
    bus_access(1'b1, `SAC_IDX_CTL_FIRST, 32'h0000_0081);
    repeat (2) @(posedge mclk);
    check_val({31'h0, acquire}, 32'h0, "acquire after abort");
    n = 0;
    while (acquire !== 1'b1 && n < 100)
    begin
      @(posedge mclk);
      n++;
    end
    check_range(n, 16, 18, "wait after abort");
    bus_access(1'b0, `SAC_IDX_FLAGS, 32'h0);
    check_val(rd, 32'h0, "flag after abort");
    bus_access(1'b0, `SAC_IDX_RES_UPPER, 32'h0);
    check_val(rd, {24'h0, lastRes[15:8]}, "kept upper");
    bus_access(1'b0, `SAC_IDX_RES_LOWER, 32'h0);
    check_val(rd, {24'h0, lastRes[7:0]}, "kept lower");
    $display("test abort done");
    print_verdict();
  end
endmodule
